// ### verilog/sfp_pkg.sv
// sfp_pkg: constants, encodings and types shared by the serial protected byte memory.
// assumes: every user refers to names as sfp_pkg::name, nothing is imported.
package sfp_pkg;

  // ---------------------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W        = 19;
  localparam int          DATA_W        = 8;
  localparam int          MEM_DEPTH     = 524288;
  localparam logic [18:0] ADDR_TOP      = 19'h7FFFF;
  localparam logic [18:0] PROT_QUARTER  = 19'h60000;
  localparam logic [18:0] PROT_HALF     = 19'h40000;
  localparam logic [18:0] PROT_ALL      = 19'h00000;

  // ---------------------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_MEM_WRITE     = 8'h02;
  localparam logic [7:0] OPC_MEM_READ      = 8'h03;

  // ---------------------------------------------------------------------------
  // write_protect_status field positions and fixed values
  // ---------------------------------------------------------------------------
  localparam int         SR_BUSY_BIT    = 0;
  localparam int         SR_WEL_BIT     = 1;
  localparam int         SR_BP_LOW_BIT  = 2;
  localparam int         SR_BP_HIGH_BIT = 3;
  localparam int         SR_PIN_EN_BIT  = 7;
  localparam logic [7:0] SR_FIXED_ONES  = 8'h40;
  localparam logic [2:0] NV_PROT_RESET  = 3'h0;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

  // ---------------------------------------------------------------------------
  // command sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFP_OPCODE,
    SFP_ADDRESS,
    SFP_WRITE_DATA,
    SFP_READ_DATA,
    SFP_STATUS_OUT,
    SFP_STATUS_IN,
    SFP_IGNORE
  } sfp_state_e;

endpackage : sfp_pkg

// ### verilog/sfp_sync.sv
// sfp_sync: two-flop synchronisers for the serial pins.
// assumes: inputs are asynchronous to clk_sys; only the second stage is read.
`timescale 1ns/1ps
module sfp_sync
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // pins
  input  wire logic [3:0] pin_async,
  // synchronised levels
  output logic      [3:0] pin_sync
);

  logic [3:0] stage_one;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage_one <= 4'hF;
      pin_sync  <= 4'hF;
    end
    else
    begin
      stage_one <= pin_async;
      pin_sync  <= stage_one;
    end
  end

endmodule : sfp_sync

// ### verilog/sfp_array.sv
// sfp_array: the nonvolatile byte array and the nonvolatile protect bits.
// assumes: contents survive rst, as they would survive a power cycle.
`timescale 1ns/1ps
module sfp_array
(
  // clock
  input  wire logic        clk_sys,
  // byte write port
  input  wire logic        mem_we,
  input  wire logic [18:0] mem_waddr,
  input  wire logic [7:0]  mem_wdata,
  // byte read port, combinational
  input  wire logic [18:0] mem_raddr,
  output logic      [7:0]  mem_rdata,
  // protect bits: pin enable, block_protect_high, block_protect_low
  input  wire logic        prot_we,
  input  wire logic [2:0]  prot_wdata,
  output logic      [2:0]  prot
);

  // no reset on purpose: this storage models the nonvolatile cells
  logic [7:0] cells [sfp_pkg::MEM_DEPTH];
  logic [2:0] nv_prot = sfp_pkg::NV_PROT_RESET;

  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      cells[mem_waddr] <= mem_wdata;
    if (prot_we)
      nv_prot <= prot_wdata;
  end

  assign mem_rdata = cells[mem_raddr];
  assign prot      = nv_prot;

endmodule : sfp_array

// ### verilog/sfp_core.sv
// sfp_core: command logic of a serial-bus nonvolatile byte memory with write protection.
// assumes: clk_sys is far faster than the serial clock, which is sampled as a plain input.
// assumes: each serial clock phase lasts at least four clk_sys cycles.
//
// Operation
// - write-disable opcode clears the write-enable latch, refusing later writes.
// - status bits 0, 4, 5 read zero, bit 6 reads one, unwritable.
// - status bit 1 shows the write-enable latch, zero after power-up.
// - status write never sets the latch; only its commands do.
// - the two block-protect bits are kept in nonvolatile storage.
// - protect pair selects none, upper quarter, upper half or whole array.
// - protect-enable bit gates the pin; low pin then blocks status writes.
// - array byte written only with latch set and address unprotected.
// - status-read opcode shifts out the status byte, most significant bit first.
// - status-write loads enable and protect bits when permitted, then clears latch.
// - three address bytes follow, most significant first; only 19 bits used.
// - further write bytes go to sequential addresses while selected.
// - data bytes commit after the eighth clock; partial bytes are dropped.
// - burst write hitting a protected address stops and ignores the rest.
// - read drives the addressed byte over eight clocks, then sequential bytes.
// - chip select rising ends a read and releases the serial output.
// - burst address counter wraps from top address to zero.
// - status bit 0 reads zero; no wake-up busy period exists here.
// - write-enable opcode sets the latch, permitting the write commands.
// - latch clears at the select rising edge ending a memory write or an accepted status write.
// - unknown opcode: ignore input until next select, output stays released.
// - serial clock level at select picks mode 0 or 3; sample on rises.
`timescale 1ns/1ps
module sfp_core
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // serial pins from the bus master
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  // serial output, enable low while driven
  output logic      so,
  output logic      so_oe_n,
  // detected bus mode, high for mode 3
  output logic      spi_mode3
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    // sequencing
    sfp_pkg::sfp_state_e state;
    logic                sck_q;
    logic                sel_q;
    logic [2:0]          bit_cnt;
    logic [1:0]          addr_cnt;
    // shifters and address
    logic [7:0]          shreg;
    logic [7:0]          txreg;
    logic [18:0]         addr;
    // command state
    logic                is_write;
    logic                write_enable_latch;
    logic                clr_at_end;
    logic                wr_stop;
    logic                load_pend;
    logic                mode3;
    // registered outputs and storage writes
    logic                so;
    logic                so_oe_n;
    logic                mem_we;
    logic [18:0]         mem_waddr;
    logic [7:0]          mem_wdata;
    logic                prot_we;
    logic [2:0]          prot_wdata;
  } sfp_core_s;

  sfp_core_s  cur;
  sfp_core_s  next_cur;
  logic [3:0] pin_sync;
  logic [7:0] mem_rdata;
  logic [2:0] prot;
  logic       sck_s;
  logic       sel_s;
  logic       si_s;
  logic       wp_n_s;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic addr_protected(input logic [18:0] a, input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'h1:    hit = (a >= sfp_pkg::PROT_QUARTER);
      2'h2:    hit = (a >= sfp_pkg::PROT_HALF);
      // whole array: the compare against zero always hits
      2'h3:    hit = (a >= sfp_pkg::PROT_ALL);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_protected

  function automatic logic [18:0] addr_step(input logic [18:0] a);
    return (a == sfp_pkg::ADDR_TOP) ? 19'h00000 : 19'(a + 19'h00001);
  endfunction : addr_step

  function automatic logic [7:0] status_byte(input logic [2:0] p, input logic write_enable_latch);
    logic [7:0] s;
    s = sfp_pkg::SR_FIXED_ONES;
    s[sfp_pkg::SR_PIN_EN_BIT]  = p[2];
    s[sfp_pkg::SR_BP_HIGH_BIT] = p[1];
    s[sfp_pkg::SR_BP_LOW_BIT]  = p[0];
    s[sfp_pkg::SR_WEL_BIT]     = write_enable_latch;
    s[sfp_pkg::SR_BUSY_BIT]    = 1'b0;
    return s;
  endfunction : status_byte

  // ---------------------------------------------------------------------------
  // pins and storage
  // ---------------------------------------------------------------------------
  sfp_sync u_sync
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_async ({sck, cs_n, si, wp_n}),
    .pin_sync  (pin_sync)
  );

  assign sck_s  = pin_sync[3];
  assign sel_s  = ~pin_sync[2];
  assign si_s   = pin_sync[1];
  assign wp_n_s = pin_sync[0];

  sfp_array u_array
  (
    .clk_sys    (clk_sys),
    .mem_we     (cur.mem_we),
    .mem_waddr  (cur.mem_waddr),
    .mem_wdata  (cur.mem_wdata),
    .mem_raddr  (cur.addr),
    .mem_rdata  (mem_rdata),
    .prot_we    (cur.prot_we),
    .prot_wdata (cur.prot_wdata),
    .prot       (prot)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic       rise;
    logic       fall;
    logic       byte_done;
    logic [7:0] nb;
    logic       sr_ok;
    rise      = 1'b0;
    fall      = 1'b0;
    byte_done = 1'b0;
    nb        = 8'h00;
    sr_ok     = 1'b0;
    next_cur  = cur;
    next_cur.sck_q   = sck_s;
    next_cur.sel_q   = sel_s;
    next_cur.mem_we  = 1'b0;
    next_cur.prot_we = 1'b0;
    // edges count only inside a frame, so the select edge itself never shifts a bit
    rise = sck_s & ~cur.sck_q & sel_s & cur.sel_q;
    fall = ~sck_s & cur.sck_q & sel_s & cur.sel_q;
    nb   = {cur.shreg[6:0], si_s};
    sr_ok = cur.write_enable_latch & ~(prot[2] & ~wp_n_s);

    // refill the transmit byte one cycle after the read address moves
    if (cur.load_pend)
    begin
      next_cur.txreg     = mem_rdata;
      next_cur.load_pend = 1'b0;
    end

    if (sel_s & ~cur.sel_q)
    begin
      // new frame: mode from the clock level, bit counters restart
      next_cur.state     = sfp_pkg::SFP_OPCODE;
      next_cur.mode3     = sck_s;
      next_cur.bit_cnt   = 3'h0;
      next_cur.addr_cnt  = 2'h0;
      next_cur.wr_stop   = 1'b0;
      next_cur.load_pend = 1'b0;
    end
    else if (~sel_s & cur.sel_q)
    begin
      // frame end: partial bytes are simply dropped with the counters
      next_cur.state   = sfp_pkg::SFP_IGNORE;
      next_cur.so_oe_n = 1'b1;
      next_cur.so      = 1'b0;
      if (cur.clr_at_end)
        next_cur.write_enable_latch = 1'b0;
      next_cur.clr_at_end = 1'b0;
    end
    else if (rise)
    begin
      next_cur.shreg   = nb;
      next_cur.bit_cnt = 3'(cur.bit_cnt + 3'h1);
      byte_done        = (cur.bit_cnt == sfp_pkg::BIT_LAST);
    end
    else if (fall)
    begin
      // output changes on the falling edge so the master samples it on the rise
      if (cur.state == sfp_pkg::SFP_READ_DATA || cur.state == sfp_pkg::SFP_STATUS_OUT)
      begin
        next_cur.so      = cur.txreg[7];
        next_cur.txreg   = {cur.txreg[6:0], 1'b0};
        next_cur.so_oe_n = 1'b0;
      end
    end

    // a whole byte is in: act on it according to the state
    if (byte_done)
    begin
      case (cur.state)
        sfp_pkg::SFP_OPCODE:
        begin
          case (nb)
            sfp_pkg::OPC_WRITE_ENABLE:
            begin
              next_cur.write_enable_latch   = 1'b1;
              next_cur.state = sfp_pkg::SFP_IGNORE;
            end
            sfp_pkg::OPC_WRITE_DISABLE:
            begin
              next_cur.write_enable_latch   = 1'b0;
              next_cur.state = sfp_pkg::SFP_IGNORE;
            end
            sfp_pkg::OPC_STATUS_READ:
            begin
              next_cur.txreg = status_byte(prot, cur.write_enable_latch);
              next_cur.state = sfp_pkg::SFP_STATUS_OUT;
            end
            sfp_pkg::OPC_STATUS_WRITE:
              next_cur.state = sfp_pkg::SFP_STATUS_IN;
            sfp_pkg::OPC_MEM_WRITE:
            begin
              next_cur.is_write   = 1'b1;
              next_cur.clr_at_end = 1'b1;
              next_cur.state      = sfp_pkg::SFP_ADDRESS;
            end
            sfp_pkg::OPC_MEM_READ:
            begin
              next_cur.is_write = 1'b0;
              next_cur.state    = sfp_pkg::SFP_ADDRESS;
            end
            default:
              next_cur.state = sfp_pkg::SFP_IGNORE;
          endcase
        end
        sfp_pkg::SFP_ADDRESS:
        begin
          // upper five address bits fall off the top of the 19-bit counter
          next_cur.addr     = {cur.addr[10:0], nb};
          next_cur.addr_cnt = 2'(cur.addr_cnt + 2'h1);
          if (cur.addr_cnt == sfp_pkg::ADDR_BYTE_LAST)
          begin
            if (cur.is_write)
              next_cur.state = sfp_pkg::SFP_WRITE_DATA;
            else
            begin
              next_cur.state     = sfp_pkg::SFP_READ_DATA;
              next_cur.load_pend = 1'b1;
            end
          end
        end
        sfp_pkg::SFP_WRITE_DATA:
        begin
          // each byte lands one cycle after its eighth clock; there is no page buffer
          if (cur.write_enable_latch && !cur.wr_stop)
          begin
            if (addr_protected(cur.addr, prot[1:0]))
              next_cur.wr_stop = 1'b1;
            else
            begin
              next_cur.mem_we    = 1'b1;
              next_cur.mem_waddr = cur.addr;
              next_cur.mem_wdata = nb;
              next_cur.addr      = addr_step(cur.addr);
            end
          end
        end
        sfp_pkg::SFP_READ_DATA:
        begin
          // the array is read a cycle after the address moves, long before the next fall
          next_cur.addr      = addr_step(cur.addr);
          next_cur.load_pend = 1'b1;
        end
        sfp_pkg::SFP_STATUS_OUT:
          next_cur.txreg = status_byte(prot, cur.write_enable_latch);
        sfp_pkg::SFP_STATUS_IN:
        begin
          // the latch itself is never loaded from the data byte
          // a refused write keeps the latch set, so a retry needs no new write-enable
          if (sr_ok)
          begin
            next_cur.prot_we    = 1'b1;
            next_cur.prot_wdata = {nb[sfp_pkg::SR_PIN_EN_BIT], nb[sfp_pkg::SR_BP_HIGH_BIT],
                                   nb[sfp_pkg::SR_BP_LOW_BIT]};
            next_cur.clr_at_end = 1'b1;
          end
          next_cur.state = sfp_pkg::SFP_IGNORE;
        end
        default:
          next_cur.state = sfp_pkg::SFP_IGNORE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // array and protect bits are untouched: they model nonvolatile cells
      cur            <= '0;
      cur.state      <= sfp_pkg::SFP_IGNORE;
      cur.sck_q      <= 1'b1;
      cur.so_oe_n    <= 1'b1;
      cur.write_enable_latch        <= 1'b0;
    end
    else
      cur <= next_cur;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign so        = cur.so;
  assign so_oe_n   = cur.so_oe_n;
  assign spi_mode3 = cur.mode3;

endmodule : sfp_core

// ### verification/sfp_checker.sv
// sfp_checker: port-level assertions for sfp_core.
// assumes: bound to sfp_core; serial pins are slow against clk_sys.
`timescale 1ns/1ps
module sfp_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic spi_mode3
);
  // ---------------------------------------------------------------------------
  // raw frame view, ahead of the core's synchronisers
  // ---------------------------------------------------------------------------
  logic       sck_q;
  logic [5:0] bits;
  logic [7:0] op;
  logic       rise;
  assign rise = sck && !sck_q && !cs_n;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      bits  <= 6'h00;
      op    <= 8'h00;
    end
    else
    begin
      sck_q <= sck;
      if (cs_n)
        bits <= 6'h00;
      else if (rise && bits != 6'h3F)
        bits <= bits + 6'h01;
      if (rise && bits < 6'h08)
        op <= {op[6:0], si};
    end
  end
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_release_on_deselect: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
    else $error("output not released after deselect");
  a_idle_released: assert property (cs_n [*5] |-> so_oe_n)
    else $error("output driven while deselected");
  a_mode3_pick: assert property ($fell(cs_n) && sck |-> ##[2:5] spi_mode3)
    else $error("mode 3 not detected");
  a_mode0_pick: assert property ($fell(cs_n) && !sck |-> ##[2:5] !spi_mode3)
    else $error("mode 0 not detected");
  a_mode_hold: assert property ((!cs_n) [*6] |-> $stable(spi_mode3))
    else $error("mode changed inside a frame");
  a_so_steady: assert property ((sck && !cs_n) [*7] |-> $stable(so))
    else $error("serial output moved while clock high");
  a_foreign_silent: assert property (bits >= 6'h08 && op != sfp_pkg::OPC_MEM_READ
    && op != sfp_pkg::OPC_STATUS_READ |-> so_oe_n)
    else $error("output driven for a non-read opcode");
  a_status_drive: assert property (bits >= 6'h08 && op == sfp_pkg::OPC_STATUS_READ
    && $fell(sck) |-> ##[2:5] !so_oe_n)
    else $error("status byte not driven");
  a_read_drive: assert property (bits >= 6'h20 && op == sfp_pkg::OPC_MEM_READ
    && $fell(sck) |-> ##[2:5] !so_oe_n)
    else $error("read data not driven");
  c_status_read: cover property (bits == 6'h10 && op == sfp_pkg::OPC_STATUS_READ);
  c_mem_read: cover property (bits == 6'h28 && op == sfp_pkg::OPC_MEM_READ);
  c_mode3: cover property ($fell(cs_n) && sck);
endmodule : sfp_checker

bind sfp_core sfp_checker u_sfp_checker (.clk_sys(clk_sys), .rst(rst), .sck(sck),
  .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .spi_mode3(spi_mode3));

// ### verification/sfp_spi_master.sv
// sfp_spi_master: behavioural bus master for the serial memory.
// assumes: paced by clk_sys; serial clock period 16 clk_sys cycles.
`timescale 1ns/1ps
module sfp_spi_master
(
  // pacing clock
  input  wire logic clk_sys,
  // from the device
  input  wire logic so,
  // to the device
  output logic      sck,
  output logic      cs_n,
  output logic      si
);
  logic idle_hi;
  initial
  begin
    idle_hi = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic wait_half();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : wait_half
  // clock rests at the mode's idle level before select
  task automatic sel(input logic m3);
    idle_hi = m3;
    sck = m3;
    wait_half();
    cs_n = 1'b0;
    wait_half();
  endtask : sel
  // n below 8 leaves a partial byte
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      wait_half();
      sck = 1'b1;
      rx = {rx[6:0], so};
      wait_half();
    end
  endtask : xfer
  // every command ends its own frame
  task automatic desel();
    sck = idle_hi;
    wait_half();
    cs_n = 1'b1;
    si = ~si;
    wait_half();
  endtask : desel
endmodule : sfp_spi_master

// ### verification/testbench.sv
// testbench: command-level tests of sfp_core through a bus master model.
// assumes: sfp_spi_master drives the serial pins; bench drives wp_n and rst.
`timescale 1ns/1ps
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       wp_n = 1'b1;
  logic       m3 = 1'b0;
  logic       sck, cs_n, si, so, so_oe_n, spi_mode3;
  logic [7:0] rx;
  logic [7:0] rd [5];
  logic [23:0] pa [4] = '{24'h01FFFF, 24'h05FFFF, 24'h03FFFF, 24'h00FFFF};
  int         nw [4] = '{2, 1, 1, 0};
  int         err_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  always #5 clk_sys = ~clk_sys;
  sfp_core u_sfp_core (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .spi_mode3(spi_mode3));
  sfp_spi_master u_sfp_spi_master (.clk_sys(clk_sys), .so(so), .sck(sck), .cs_n(cs_n),
    .si(si));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int na);
    u_sfp_spi_master.sel(m3);
    u_sfp_spi_master.xfer(op, 8, rx);
    for (int i = 0; i < na; i++)
      u_sfp_spi_master.xfer(a[23 - 8 * i -: 8], 8, rx);
  endtask : send
  task automatic op1(input logic [7:0] op);
    send(op, 24'h000000, 0);
    u_sfp_spi_master.desel();
  endtask : op1
  task automatic rd_sr(input logic [7:0] exp);
    send(sfp_pkg::OPC_STATUS_READ, 24'h000000, 0);
    u_sfp_spi_master.xfer(8'h00, 8, rx);
    u_sfp_spi_master.desel();
    check("status", exp, rx);
  endtask : rd_sr
  task automatic wr_sr(input logic [7:0] v);
    send(sfp_pkg::OPC_STATUS_WRITE, 24'h000000, 0);
    u_sfp_spi_master.xfer(v, 8, rx);
    u_sfp_spi_master.desel();
  endtask : wr_sr
  task automatic wr_mem(input logic en, input logic [23:0] a, input logic [7:0] d,
                        input int n);
    if (en)
      op1(sfp_pkg::OPC_WRITE_ENABLE);
    send(sfp_pkg::OPC_MEM_WRITE, a, 3);
    for (int i = 0; i < n; i++)
      u_sfp_spi_master.xfer(d + 8'(i), 8, rx);
    u_sfp_spi_master.desel();
  endtask : wr_mem
  task automatic rd_mem(input logic [23:0] a, input int n);
    send(sfp_pkg::OPC_MEM_READ, a, 3);
    for (int i = 0; i < n; i++)
      u_sfp_spi_master.xfer(8'hFF, 8, rd[i]);
    u_sfp_spi_master.desel();
  endtask : rd_mem
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rd_sr(8'h40);
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    rd_sr(8'h42);
    op1(sfp_pkg::OPC_WRITE_DISABLE);
    rd_sr(8'h40);
    wr_mem(1'b1, 24'h000002, 8'h11, 1);
    rd_sr(8'h40);
    wr_mem(1'b0, 24'h000002, 8'h55, 1);
    $display("test latch done");
    m3 = 1'b1;
    wr_mem(1'b1, 24'hFFFFFE, 8'hE0, 4);
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    send(sfp_pkg::OPC_MEM_WRITE, 24'h000002, 3);
    u_sfp_spi_master.xfer(8'hFF, 4, rx);
    u_sfp_spi_master.desel();
    rd_mem(24'h07FFFE, 5);
    for (int i = 0; i < 4; i++)
      check("burst", 8'hE0 + 8'(i), rd[i]);
    check("refused_partial", 8'h11, rd[4]);
    check("mode", 8'h01, {7'h00, spi_mode3});
    check("released", 8'h01, {7'h00, so_oe_n});
    $display("test burst done");
    m3 = 1'b0;
    for (int k = 0; k < 4; k++)
      wr_mem(1'b1, pa[k], 8'h5A, 2);
    for (int k = 0; k < 4; k++)
    begin
      op1(sfp_pkg::OPC_WRITE_ENABLE);
      wr_sr(8'h73 | 8'(k << 2));
      rd_sr(8'h40 | 8'(k << 2));
      wr_mem(1'b1, pa[k], 8'hA0, 2);
      rd_mem(pa[k], 2);
      for (int j = 0; j < 2; j++)
        check("protect", j < nw[k] ? 8'hA0 + 8'(j) : 8'h5A + 8'(j), rd[j]);
    end
    check("mode", 8'h00, {7'h00, spi_mode3});
    $display("test protect done");
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    wr_sr(8'h80);
    rd_sr(8'hC0);
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    wp_n = 1'b0;
    wr_sr(8'h8C);
    rd_sr(8'hC2);
    wr_mem(1'b0, 24'h000020, 8'h77, 1);
    rd_mem(24'h000020, 1);
    check("pin_mem", 8'h77, rd[0]);
    rd_sr(8'hC0);
    wp_n = 1'b1;
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    wr_sr(8'h04);
    op1(sfp_pkg::OPC_WRITE_ENABLE);
    send(8'hAB, 24'h040000, 1);
    u_sfp_spi_master.desel();
    rd_sr(8'h46);
    $display("test pin done");
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rd_sr(8'h44);
    rd_mem(24'h000002, 1);
    check("kept", 8'h11, rd[0]);
    $display("test reset done");
    end_sim();
  end
endmodule : testbench
